/* File: logic/pkalu_pkg.sv */
// Shared constants and types for the packed integer execution datapath.
// Assumes a 64-bit vector register file and a single core clock.
package pkalu_pkg;
  // Operand and lane geometry
  localparam int unsigned VEC_W = 64;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned N_WORDS = 4;
  localparam int unsigned N_BYTES = 8;
  localparam int unsigned N_DWORDS = 2;
  localparam int unsigned REG_IDX_W = 3;
  // Result latency in cycles from issue to result valid
  localparam int unsigned ALU_LATENCY = 1;
  // Values after reset
  localparam logic [63:0] RESULT_RST = 64'h0000_0000_0000_0000;
  localparam logic [2:0] DEST_RST = 3'h0;
  // Carry-in used by the rounding average
  localparam logic AVG_CARRY_IN = 1'b1;
  // Operation codes
  typedef enum logic [4:0] {
    OP_MAX_SW = 5'b00000,
    OP_MIN_SW = 5'b00001,
    OP_MAX_UB = 5'b00010,
    OP_MIN_UB = 5'b00011,
    OP_MULHI_UW = 5'b00100,
    OP_MULHI_SW = 5'b00101,
    OP_SAD_UB = 5'b00110,
    OP_AVG_UB = 5'b00111,
    OP_AVG_UW = 5'b01000,
    OP_MADD_SW = 5'b01001,
    OP_ADD_B = 5'b01010,
    OP_ADD_W = 5'b01011,
    OP_SUB_B = 5'b01100,
    OP_SUB_W = 5'b01101,
    OP_ADDS_SB = 5'b01110,
    OP_ADDS_SW = 5'b01111,
    OP_ADDUS_UB = 5'b10000,
    OP_ADDUS_UW = 5'b10001,
    OP_SUBS_SB = 5'b10010,
    OP_SUBS_SW = 5'b10011,
    OP_SUBUS_UB = 5'b10100,
    OP_SUBUS_UW = 5'b10101
  } alu_op_t;
endpackage

/* File: logic/lane_sat_add.sv */
// Single-lane add or subtract with optional signed or unsigned saturation.
// Assumes the width is a byte or a word; the caller picks the mode.
`timescale 1ns/1ps
module lane_sat_add
  import pkalu_pkg::*;
#(
  parameter int unsigned W = 8
)
(
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic sub,
  input wire logic sat,
  input wire logic sgn,
  output logic [W-1:0] y
);
  // Extended result keeps the carry or borrow
  logic [W:0] ext;
  // Signed overflow flag
  logic ovf;

  // Sum and clamp
  always_comb
  begin
    ext = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    ovf = sub ? ((a[W-1] != b[W-1]) && (ext[W-1] != a[W-1]))
              : ((a[W-1] == b[W-1]) && (ext[W-1] != a[W-1]));
    y = ext[W-1:0];
    // Saturation matches signedness of the operands
    if (sat && sgn && ovf)
    begin
      // Clamp toward the sign of the first operand
      y = a[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
    end
    else if (sat && !sgn && ext[W])
    begin
      // Borrow clamps to zero, carry clamps to all ones
      y = sub ? {W{1'b0}} : {W{1'b1}};
    end
  end
endmodule

/* File: logic/packed_minmax_avg_sad_alu.sv */
// Packed integer execution datapath for 64-bit vector operands.
// Assumes the issue logic presents operands and a one-cycle issue strobe;
// the second operand is already fetched from a register or memory.
// Function
// - Signed word max per four lanes
// - Signed word min per four lanes
// - Unsigned byte max per eight lanes
// - Unsigned byte min per eight lanes
// - Destination register; source register or memory
// - Multiply-high keeps upper 16 of 32 bits
// - Byte absolute differences summed into low word
// - Upper three words cleared after difference sum
// - Average adds elements plus carry, keeps carry
// - Average sum shifted right one bit, per lane
// - Carry fills top bit of average result
// - Average comes in byte and word widths
// - Saturating forms only for bytes and words
// - Saturation mode always matches operand signedness
// - Plain word add wraps modulo sixteen bits
// - Multiply-add: four products, two pair sums
`timescale 1ns/1ps
module packed_minmax_avg_sad_alu
  import pkalu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic issue,
  input wire alu_op_t op,
  input wire logic [63:0] dst_val,
  input wire logic [63:0] src_val,
  input wire logic src_from_mem,
  input wire logic [2:0] dst_idx,
  output logic result_valid,
  output logic [63:0] result,
  output logic [2:0] result_idx,
  output logic result_from_mem
);

  // All state of the block in one record
  typedef struct packed {
    logic valid;
    logic [63:0] data;
    logic [2:0] idx;
    logic mem;
  } alu_state_t;

  alu_state_t state_q;
  alu_state_t state_d;

  // Word lane of a vector
  function automatic logic [15:0] word_of(input logic [63:0] v, input int unsigned i);
    word_of = v[i*WORD_W +: WORD_W];
  endfunction

  // Byte lane of a vector
  function automatic logic [7:0] byte_of(input logic [63:0] v, input int unsigned i);
    byte_of = v[i*BYTE_W +: BYTE_W];
  endfunction

  // Signed 16x16 product, used by signed multiply-high and multiply-add
  function automatic logic [31:0] smul16(input logic [15:0] a, input logic [15:0] b);
    // Widen first so the product is formed at full width, not at 16 bits
    smul16 = 32'($signed(a)) * 32'($signed(b));
  endfunction

  // Saturating lane results from the shared add/sub cell
  logic [63:0] sat_b;
  logic [63:0] sat_w;
  logic sat_sub;
  logic sat_on;
  logic sat_sgn;

  // Decode of the add/sub family; signedness only selects the clamp, the wrapped sum is the same
  always_comb
  begin
    sat_sub = (op == OP_SUB_B) || (op == OP_SUB_W) || (op == OP_SUBS_SB) || (op == OP_SUBS_SW)
              || (op == OP_SUBUS_UB) || (op == OP_SUBUS_UW);
    sat_on = !((op == OP_ADD_B) || (op == OP_ADD_W) || (op == OP_SUB_B) || (op == OP_SUB_W));
    sat_sgn = (op == OP_ADDS_SB) || (op == OP_ADDS_SW) || (op == OP_SUBS_SB) || (op == OP_SUBS_SW);
  end

  genvar g;
  generate
    for (g = 0; g < N_BYTES; g++)
    begin : g_byte
      lane_sat_add #(.W(BYTE_W)) u_b (
        .a(dst_val[g*BYTE_W +: BYTE_W]),
        .b(src_val[g*BYTE_W +: BYTE_W]),
        .sub(sat_sub),
        .sat(sat_on),
        .sgn(sat_sgn),
        .y(sat_b[g*BYTE_W +: BYTE_W])
      );
    end
    for (g = 0; g < N_WORDS; g++)
    begin : g_word
      lane_sat_add #(.W(WORD_W)) u_w (
        .a(dst_val[g*WORD_W +: WORD_W]),
        .b(src_val[g*WORD_W +: WORD_W]),
        .sub(sat_sub),
        .sat(sat_on),
        .sgn(sat_sgn),
        .y(sat_w[g*WORD_W +: WORD_W])
      );
    end
  endgenerate

  // Datapath result for the selected operation
  logic [63:0] res;
  logic [15:0] sad_sum;
  logic [8:0] bsum;
  logic [16:0] wsum;
  logic [31:0] prod;
  logic [7:0] ba;
  logic [7:0] bb;
  logic [15:0] wa;
  logic [15:0] wb;

  always_comb
  begin
    res = RESULT_RST;
    sad_sum = 16'h0000;
    bsum = 9'h000;
    wsum = 17'h0_0000;
    prod = 32'h0000_0000;
    ba = 8'h00;
    bb = 8'h00;
    wa = 16'h0000;
    wb = 16'h0000;
    unique case (op)
      OP_MAX_SW, OP_MIN_SW:
      begin
        for (int i = 0; i < N_WORDS; i++)
        begin
          wa = word_of(dst_val, i);
          wb = word_of(src_val, i);
          if (op == OP_MAX_SW)
            res[i*WORD_W +: WORD_W] = ($signed(wa) > $signed(wb)) ? wa : wb;
          else
            res[i*WORD_W +: WORD_W] = ($signed(wa) < $signed(wb)) ? wa : wb;
        end
      end
      OP_MAX_UB, OP_MIN_UB:
      begin
        for (int i = 0; i < N_BYTES; i++)
        begin
          ba = byte_of(dst_val, i);
          bb = byte_of(src_val, i);
          if (op == OP_MAX_UB)
            res[i*BYTE_W +: BYTE_W] = (ba > bb) ? ba : bb;
          else
            res[i*BYTE_W +: BYTE_W] = (ba < bb) ? ba : bb;
        end
      end
      OP_MULHI_UW, OP_MULHI_SW:
      begin
        for (int i = 0; i < N_WORDS; i++)
        begin
          wa = word_of(dst_val, i);
          wb = word_of(src_val, i);
          prod = (op == OP_MULHI_SW) ? smul16(wa, wb) : (32'(wa) * 32'(wb));
          res[i*WORD_W +: WORD_W] = prod[31:16];
        end
      end
      OP_SAD_UB:
      begin
        for (int i = 0; i < N_BYTES; i++)
        begin
          ba = byte_of(dst_val, i);
          bb = byte_of(src_val, i);
          sad_sum = sad_sum + 16'((ba > bb) ? (ba - bb) : (bb - ba));
        end
        res = {48'h0000_0000_0000, sad_sum};
      end
      OP_AVG_UB:
      begin
        for (int i = 0; i < N_BYTES; i++)
        begin
          bsum = {1'b0, byte_of(dst_val, i)} + {1'b0, byte_of(src_val, i)} + 9'(AVG_CARRY_IN);
          res[i*BYTE_W +: BYTE_W] = bsum[8:1];
        end
      end
      OP_AVG_UW:
      begin
        for (int i = 0; i < N_WORDS; i++)
        begin
          wsum = {1'b0, word_of(dst_val, i)} + {1'b0, word_of(src_val, i)} + 17'(AVG_CARRY_IN);
          res[i*WORD_W +: WORD_W] = wsum[16:1];
        end
      end
      OP_MADD_SW:
      begin
        for (int i = 0; i < N_DWORDS; i++)
        begin
          res[i*32 +: 32] = smul16(word_of(dst_val, 2*i), word_of(src_val, 2*i))
                          + smul16(word_of(dst_val, 2*i+1), word_of(src_val, 2*i+1));
        end
      end
      OP_ADD_B, OP_SUB_B, OP_ADDS_SB, OP_ADDUS_UB, OP_SUBS_SB, OP_SUBUS_UB:
        res = sat_b;
      OP_ADD_W, OP_SUB_W, OP_ADDS_SW, OP_ADDUS_UW, OP_SUBS_SW, OP_SUBUS_UW:
        res = sat_w;
      // Undefined op codes give zero
      default:
        res = RESULT_RST;
    endcase
  end

  // Next state: capture on issue only; valid is a one-cycle pulse
  always_comb
  begin
    state_d = state_q;
    state_d.valid = issue;
    if (issue)
    begin
      state_d.data = res;
      state_d.idx = dst_idx;
      state_d.mem = src_from_mem;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state_q <= '{valid: 1'b0, data: RESULT_RST, idx: DEST_RST, mem: 1'b0};
    else
      state_q <= state_d;
  end

  assign result_valid = state_q.valid;
  assign result = state_q.data;
  assign result_idx = state_q.idx;
  assign result_from_mem = state_q.mem;

  // Checks
  property p_max_sw;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_MAX_SW) |=> ($signed(result[15:0]) >= $signed($past(dst_val[15:0]))
      && $signed(result[15:0]) >= $signed($past(src_val[15:0])));
  endproperty
  a_max_sw: assert property (p_max_sw) else $error("word max below an input");

  property p_min_sw;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_MIN_SW) |=> ($signed(result[63:48]) <= $signed($past(dst_val[63:48]))
      && $signed(result[63:48]) <= $signed($past(src_val[63:48])));
  endproperty
  a_min_sw: assert property (p_min_sw) else $error("word min above an input");

  property p_max_ub;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_MAX_UB) |=> (result[63:56] >= $past(dst_val[63:56])
      && result[63:56] >= $past(src_val[63:56]));
  endproperty
  a_max_ub: assert property (p_max_ub) else $error("byte max below an input");

  property p_min_ub;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_MIN_UB) |=> (result[7:0] <= $past(dst_val[7:0]) && result[7:0] <= $past(src_val[7:0]));
  endproperty
  a_min_ub: assert property (p_min_ub) else $error("byte min above an input");

  sequence s_sad_issue;
    issue && op == OP_SAD_UB;
  endsequence
  property p_sad_clear;
    @(posedge ref_clk) disable iff (rst)
    s_sad_issue |=> (result_valid && result[63:16] == 48'h0000_0000_0000);
  endproperty
  a_sad_clear: assert property (p_sad_clear) else $error("difference sum upper words not zero");

  property p_sad_equal;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_SAD_UB && dst_val == src_val) |=> (result == 64'h0000_0000_0000_0000);
  endproperty
  a_sad_equal: assert property (p_sad_equal) else $error("difference sum of equal inputs not zero");

  property p_avg_ub;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_AVG_UB && dst_val[63:56] == 8'hff && src_val[63:56] == 8'hff) |=> (result[63:56] == 8'hff);
  endproperty
  a_avg_ub: assert property (p_avg_ub) else $error("byte average lost carry");

  property p_avg_uw_round;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_AVG_UW && dst_val[15:0] == 16'h0000 && src_val[15:0] == 16'h0001)
      |=> (result[15:0] == 16'h0001);
  endproperty
  a_avg_uw_round: assert property (p_avg_uw_round) else $error("word average not rounded up");

  property p_add_wrap;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_ADD_W) |=> (result[31:16] == 16'($past(dst_val[31:16]) + $past(src_val[31:16])));
  endproperty
  a_add_wrap: assert property (p_add_wrap) else $error("word add did not wrap");

  property p_dest;
    @(posedge ref_clk) disable iff (rst)
    issue |=> (result_valid && result_idx == $past(dst_idx)) ##1 (!result_valid || $past(issue));
  endproperty
  a_dest: assert property (p_dest) else $error("result not sent to destination register");

  // Largest unsigned operands keep the carry of the product
  property p_mulhi_uw;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_MULHI_UW && dst_val[63:48] == 16'hffff && src_val[63:48] == 16'hffff)
      |=> (result[63:48] == 16'hfffe);
  endproperty
  a_mulhi_uw: assert property (p_mulhi_uw) else $error("unsigned high product wrong");

  // Minus one squared is plus one, so the high half is zero
  property p_mulhi_sw;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_MULHI_SW && dst_val[63:48] == 16'hffff && src_val[63:48] == 16'hffff)
      |=> (result[63:48] == 16'h0000);
  endproperty
  a_mulhi_sw: assert property (p_mulhi_sw) else $error("signed high product wrong");

  // Two most negative products wrap into the top dword
  property p_madd_pair;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_MADD_SW && dst_val[63:32] == 32'h8000_8000 && src_val[63:32] == 32'h8000_8000)
      |=> (result[63:32] == 32'h8000_0000);
  endproperty
  a_madd_pair: assert property (p_madd_pair) else $error("pair sum of products wrong");

  // Signed word add clamps at the positive limit
  property p_adds_sw;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_ADDS_SW && dst_val[15:0] == 16'h7fff && src_val[15:0] == 16'h0001)
      |=> (result[15:0] == 16'h7fff);
  endproperty
  a_adds_sw: assert property (p_adds_sw) else $error("signed word add not clamped");

  // Unsigned byte subtract never goes below zero
  property p_subus_ub;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_SUBUS_UB && dst_val[7:0] < src_val[7:0])
      |=> (result[7:0] == 8'h00);
  endproperty
  a_subus_ub: assert property (p_subus_ub) else $error("unsigned byte subtract not clamped");

  // Word average of all-ones lanes needs the carry in its top bit
  property p_avg_uw_carry;
    @(posedge ref_clk) disable iff (rst)
    (issue && op == OP_AVG_UW && dst_val[63:48] == 16'hffff && src_val[63:48] == 16'hffff)
      |=> (result[63:48] == 16'hffff);
  endproperty
  a_avg_uw_carry: assert property (p_avg_uw_carry) else $error("word average lost carry");

endmodule

/* File: test/issue_model.sv */
// Issue and register-file stand-in that feeds the packed datapath.
// Assumes one core clock; requests are launched by NBA on the rising edge.
`timescale 1ns/1ps
module issue_model
  import pkalu_pkg::*;
(
  input wire logic ref_clk,
  output logic issue,
  output alu_op_t op,
  output logic [63:0] dst_val,
  output logic [63:0] src_val,
  output logic src_from_mem,
  output logic [2:0] dst_idx,
  input wire logic result_valid,
  input wire logic [63:0] result,
  input wire logic [2:0] result_idx,
  input wire logic result_from_mem
);
  // Quiet bus at time zero
  initial
  begin
    issue = 1'b0;
    op = OP_MAX_SW;
    dst_val = 64'h0;
    src_val = 64'h0;
    src_from_mem = 1'b0;
    dst_idx = 3'h0;
  end

  // One issue pulse, then the answer one edge later
  // register destination, either source
  task automatic send(input alu_op_t o, input logic [63:0] a, input logic [63:0] b, input logic mem,
                      input logic [2:0] idx, output logic v, output logic [63:0] r, output logic [2:0] ri,
                      output logic rm);
    @(posedge ref_clk);
    issue <= 1'b1;
    op <= o;
    dst_val <= a;
    src_val <= b;
    src_from_mem <= mem;
    dst_idx <= idx;
    @(posedge ref_clk);
    // Operands go stale on purpose so a design that resamples is caught
    issue <= 1'b0;
    dst_val <= ~a;
    src_val <= ~b;
    src_from_mem <= ~mem;
    dst_idx <= ~idx;
    #1;
    v = result_valid;
    r = result;
    ri = result_idx;
    rm = result_from_mem;
  endtask
endmodule

/* File: test/packed_minmax_avg_sad_alu_test.sv */
// Self-checking bench for the packed datapath, one task per scenario.
// Assumes the issue model drives every design input except clock and reset; results come back latency one.
`timescale 1ns/1ps
module packed_minmax_avg_sad_alu_test;
  import pkalu_pkg::*;
  logic ref_clk;
  logic rst;
  logic issue;
  alu_op_t op;
  logic [63:0] dst_val;
  logic [63:0] src_val;
  logic src_from_mem;
  logic [2:0] dst_idx;
  logic result_valid;
  logic [63:0] result;
  logic [2:0] result_idx;
  logic result_from_mem;
  int failures = 0;
  int n_tests = 0;

  packed_minmax_avg_sad_alu u_dut (.ref_clk(ref_clk), .rst(rst), .issue(issue), .op(op), .dst_val(dst_val),
    .src_val(src_val), .src_from_mem(src_from_mem), .dst_idx(dst_idx), .result_valid(result_valid),
    .result(result), .result_idx(result_idx), .result_from_mem(result_from_mem));
  issue_model u_part (.ref_clk(ref_clk), .issue(issue), .op(op), .dst_val(dst_val), .src_val(src_val),
    .src_from_mem(src_from_mem), .dst_idx(dst_idx), .result_valid(result_valid), .result(result),
    .result_idx(result_idx), .result_from_mem(result_from_mem));

  // Free-running core clock, 10 ns
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Saturation clamp shared by signed and unsigned forms
  function automatic longint clamp(longint v, longint lo, longint hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Lane-by-lane reference; wide ints avoid any wrap in the arithmetic itself
  function automatic logic [63:0] model(alu_op_t o, logic [63:0] a, logic [63:0] b);
    logic [63:0] r;
    longint s, w, m, ux, uy, sx, sy, v;
    r = 64'h0;
    s = 0;
    w = (o inside {OP_MAX_UB, OP_MIN_UB, OP_SAD_UB, OP_AVG_UB, OP_ADD_B, OP_SUB_B, OP_ADDS_SB, OP_ADDUS_UB,
                   OP_SUBS_SB, OP_SUBUS_UB}) ? 8 : 16;
    m = longint'(1) << (w - 1);
    for (int i = 0; i < 64 / w; i++)
    begin
      ux = longint'((a >> (i * w)) & 64'(2 * m - 1));
      uy = longint'((b >> (i * w)) & 64'(2 * m - 1));
      sx = (ux ^ m) - m;
      sy = (uy ^ m) - m;
      case (o)
        OP_MAX_SW: v = (sx > sy) ? sx : sy;
        OP_MIN_SW: v = (sx < sy) ? sx : sy;
        OP_MAX_UB: v = (ux > uy) ? ux : uy;
        OP_MIN_UB: v = (ux < uy) ? ux : uy;
        OP_MULHI_UW: v = (ux * uy) >> 16;
        OP_MULHI_SW: v = (sx * sy) >>> 16;
        OP_SAD_UB: v = 0;
        OP_AVG_UB, OP_AVG_UW: v = (ux + uy + 1) >> 1;
        OP_MADD_SW: v = 0;
        OP_ADD_B, OP_ADD_W: v = ux + uy;
        OP_SUB_B, OP_SUB_W: v = ux - uy;
        OP_ADDS_SB, OP_ADDS_SW: v = clamp(sx + sy, -m, m - 1);
        OP_SUBS_SB, OP_SUBS_SW: v = clamp(sx - sy, -m, m - 1);
        OP_ADDUS_UB, OP_ADDUS_UW: v = clamp(ux + uy, 0, 2 * m - 1);
        OP_SUBUS_UB, OP_SUBUS_UW: v = clamp(ux - uy, 0, 2 * m - 1);
        default: v = 0;
      endcase
      s += (o == OP_SAD_UB) ? ((ux > uy) ? ux - uy : uy - ux) : ((o == OP_MADD_SW) ? sx * sy : 0);
      r |= 64'(v & (2 * m - 1)) << (i * w);
      // Pair sums land in their dword once both products are in
      if (o == OP_MADD_SW && i % 2 == 1)
      begin
        r[32 * (i / 2) +: 32] = s[31:0];
        s = 0;
      end
    end
    if (o == OP_SAD_UB)
      r = 64'(s);
    return r;
  endfunction

  // Single compare for every result kind, widened to 64 bits
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Issue one operation and judge every echoed field
  task automatic run(input alu_op_t o, input logic [63:0] a, input logic [63:0] b, input logic mem,
                     input logic [2:0] idx);
    logic v;
    logic [63:0] r;
    logic [2:0] ri;
    logic rm;
    u_part.send(o, a, b, mem, idx, v, r, ri, rm);
    check(64'(v), 64'h1);
    check(r, model(o, a, b));
    check(64'(ri), 64'(idx));
    check(64'(rm), 64'(mem));
  endtask

  // Outputs while reset is held
  task automatic t_reset;
    check(64'(result_valid), 64'h0);
    check(result, RESULT_RST);
    check(64'(result_idx), 64'(DEST_RST));
    check(64'(result_from_mem), 64'h0);
  endtask

  // Sign boundaries where signed and unsigned order disagree
  task automatic t_minmax;
    alu_op_t ops[4] = '{OP_MAX_SW, OP_MIN_SW, OP_MAX_UB, OP_MIN_UB};
    for (int i = 0; i < 4; i++)
      run(ops[i], 64'h8000_7FFF_0001_FF80, 64'h7FFF_8000_FFFF_0081, 1'b0, 3'h1);
  endtask

  // Extreme lanes for both multiply-high forms and the pair sums
  task automatic t_mul;
    run(OP_MULHI_UW, 64'hFFFF_8000_1234_0002, 64'hFFFF_8000_5678_7FFF, 1'b1, 3'h2);
    run(OP_MULHI_SW, 64'hFFFF_8000_1234_0002, 64'hFFFF_8000_5678_7FFF, 1'b0, 3'h3);
    run(OP_MADD_SW, 64'h8000_8000_7FFF_0003, 64'h8000_8000_7FFF_FFFE, 1'b0, 3'h4);
  endtask

  // Largest byte sum; dirty upper words must clear; equal inputs sum to zero
  task automatic t_sad;
    run(OP_SAD_UB, 64'hFF00_FF00_FF00_FF00, 64'h00FF_00FF_00FF_00FF, 1'b1, 3'h6);
    check(result, 64'h0000_0000_0000_07F8);
    run(OP_SAD_UB, 64'h1234_5678_9ABC_DEF0, 64'h1234_5678_9ABC_DEF0, 1'b0, 3'h5);
    check(result, 64'h0000_0000_0000_0000);
  endtask

  // Carry out of all-ones lanes fills the top bit; odd sums round up
  task automatic t_avg;
    run(OP_AVG_UB, 64'hFFFF_0001_FF01_0000, 64'hFFFF_0000_FF00_0001, 1'b0, 3'h0);
    check(result, 64'hFFFF_0001_FF01_0001);
    run(OP_AVG_UW, 64'hFFFF_0001_FF01_0000, 64'hFFFF_0000_FF00_0001, 1'b0, 3'h7);
    check(result, 64'hFFFF_0001_FF01_0001);
  endtask

  // Every wrap and saturate form, both operand orders
  task automatic t_addsub;
    alu_op_t ops[12] = '{OP_ADD_B, OP_ADD_W, OP_SUB_B, OP_SUB_W, OP_ADDS_SB, OP_ADDS_SW, OP_ADDUS_UB,
                         OP_ADDUS_UW, OP_SUBS_SB, OP_SUBS_SW, OP_SUBUS_UB, OP_SUBUS_UW};
    for (int i = 0; i < 12; i++)
    begin
      run(ops[i], 64'h7F80_FF01_8000_7FFF, 64'h0180_01FF_8000_0001, 1'b0, 3'h5);
      run(ops[i], 64'h0180_01FF_8000_0001, 64'h7F80_FF01_8000_7FFF, 1'b1, 3'h2);
    end
    run(OP_ADD_W, 64'h1234_FFFF_8000_0000, 64'h8000_8000_8000_8000, 1'b0, 3'h1);
    check(result, 64'h9234_7FFF_0000_8000);
  endtask

  // Memory-sourced echo, hold after the pulse, unknown code yields zero
  task automatic t_echo;
    logic [63:0] kept;
    run(OP_MAX_UB, 64'h0102_0304_0506_0708, 64'h0807_0605_0403_0201, 1'b1, 3'h7);
    kept = result;
    @(posedge ref_clk);
    #1;
    check(64'(result_valid), 64'h0);
    check(result, kept);
    run(alu_op_t'(5'h1F), 64'hFFFF_FFFF_FFFF_FFFF, 64'h1, 1'b0, 3'h3);
  endtask

  // Counts, verdict and end of run
  task automatic results;
    $display("mismatches=%0d comparisons=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence: reset held ten cycles, released on an edge
  initial
  begin
    rst = 1'b1;
    repeat (9) @(posedge ref_clk);
    #1;
    t_reset;
    @(posedge ref_clk);
    rst <= 1'b0;
    t_minmax;
    t_mul;
    t_sad;
    t_avg;
    t_addsub;
    t_echo;
    results();
  end

  // Watchdog: the full run needs well under a few hundred cycles
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    results();
  end
endmodule
